// ==== core/spcb_consts.svh ====
`ifndef SPCB_CONSTS_SVH
`define SPCB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define SPCB_ADDR_FORMAT  4'h0
`define SPCB_ADDR_CONTROL 4'h1
`define SPCB_ADDR_STATUS  4'h2
`define SPCB_ADDR_TXBUF   4'h3
`define SPCB_ADDR_RXBUF   4'h4
`define SPCB_ADDR_BITRATE 4'h5
`define SPCB_ADDR_CARD    4'h6
`define SPCB_ADDR_IRQST   4'h7
`define SPCB_ADDR_IRQMSK  4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPCB_FMT_SYNC     7
`define SPCB_FMT_PAR_ON   5
`define SPCB_FMT_ODD      4
`define SPCB_FMT_MP       2
`define SPCB_CTL_TIE      7
`define SPCB_CTL_RIE      6
`define SPCB_CTL_TXON     5
`define SPCB_CTL_RXON     4
`define SPCB_CTL_AWF      3
`define SPCB_CTL_MASK     8'hf8
`define SPCB_STS_TX_BUF_EMPTY_FLAG     7
`define SPCB_STS_RX_BUF_FULL_FLAG     6
`define SPCB_STS_OVERRUN_ERR_FLAG     5
`define SPCB_STS_FER      4
`define SPCB_STS_PER      3
`define SPCB_STS_MPB      1
`define SPCB_STS_MPBT     0
`define SPCB_CARD_SEL     0
`define SPCB_IRQ_TX       0
`define SPCB_IRQ_RXF      1
`define SPCB_IRQ_RXE      2

// ----------------------------------------------------------------------
// Reset values and prescaler limits
// ----------------------------------------------------------------------
`define SPCB_RST_REG      8'h00
`define SPCB_DIV1_LIM     6'h00
`define SPCB_DIV4_LIM     6'h03
`define SPCB_DIV16_LIM    6'h0f
`define SPCB_DIV64_LIM    6'h3f

`endif

// ==== core/spcb_pkg.sv ====
package spcb_pkg;

  // One-hot state of the transmit and receive sequencers
  typedef enum logic [1:0] {
    SPCB_IDLE = 2'b01,
    SPCB_BUSY = 2'b10
  } spcb_seq_t;

endpackage

// ==== core/spcb_prescaler.sv ====
`include "spcb_consts.svh"

module spcb_prescaler (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Divider select and enable out
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [5:0] cnt_ff;
  logic [1:0] sel_q_ff;
  wire  [5:0] lim_w;
  wire        sel_chg_w;

  assign lim_w = (sel_i == 2'b00) ? `SPCB_DIV1_LIM :
                 (sel_i == 2'b01) ? `SPCB_DIV4_LIM :
                 (sel_i == 2'b10) ? `SPCB_DIV16_LIM : `SPCB_DIV64_LIM;
  assign sel_chg_w = sel_i != sel_q_ff;
  assign tick_o    = (cnt_ff == lim_w) && !sel_chg_w;

  // A new select restarts the count so the first period is whole
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff   <= 6'h00;
      sel_q_ff <= 2'b00;
    end else begin
      sel_q_ff <= sel_i;
      cnt_ff   <= (tick_o || sel_chg_w) ? 6'h00 : cnt_ff + 6'h01;
    end
  end

  sequence s_quiet3;
    !tick_o [*3] ##1 tick_o;
  endsequence

  a_div_four: assert property (@(posedge core_clk_i) disable iff (rst_i || sel_chg_w)
    (tick_o && sel_i == 2'b01) |=> s_quiet3)
    else $error("divide by four spacing wrong");

endmodule

// ==== core/spcb_rx_shift.sv ====
module spcb_rx_shift #(
  parameter int FRAME_W = 12
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Sampling control
  input  wire logic               clr_i,
  input  wire logic               sample_i,
  input  wire logic               bit_i,
  input  wire logic [3:0]         len_i,
  // Frame out
  output logic [FRAME_W-1:0]      frame_o,
  output logic                    last_o,
  output logic                    done_o
);

  logic [3:0] cnt_ff;
  wire  [3:0] idx_w;

  assign idx_w  = clr_i ? 4'h0 : cnt_ff;
  assign last_o = sample_i && (idx_w == len_i - 4'h1);

  // Bits are stored by index, so the frame reads LSB first
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= 4'h0;
      frame_o <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= last_o;
      if (sample_i) begin
        frame_o[idx_w] <= bit_i;
        cnt_ff         <= last_o ? 4'h0 : idx_w + 4'h1;
      end else if (clr_i) begin
        cnt_ff <= 4'h0;
      end
    end
  end

endmodule

// ==== core/spcb_top.sv ====
`include "spcb_consts.svh"

module spcb_top #(
  parameter int FRAME_W = 12
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Serial line
  input  wire logic       rxd_i,
  input  wire logic       sclk_i,
  output logic            txd_o,
  // Interrupt requests
  output logic            tx_empty_irq_o,
  output logic            rx_full_irq_o,
  output logic            rx_error_irq_o,
  output logic            irq_o
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] serial_format_ff;
  logic [7:0] serial_control_ff;
  logic [7:0] tx_buf_reg_ff;
  logic [7:0] rx_buf_reg_ff;
  logic [7:0] bit_rate_reg_ff;
  logic [7:0] card_mode_reg_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] req_q_ff;
  logic       tx_buf_empty_flag_ff;
  logic       rx_buf_full_flag_ff;
  logic       overrun_err_flag_ff;
  logic       framing_err_flag_ff;
  logic       parity_err_flag_ff;
  logic       addr_flag_bit_ff;
  logic       tx_addr_bit_ff;
  logic [4:0] armed_ff;
  logic [7:0] brr_cnt_ff;
  logic       sclk_q_ff;
  logic [FRAME_W-1:0] tx_frame_ff;
  logic [3:0] tx_cnt_ff;
  spcb_pkg::spcb_seq_t tx_st_ff;
  spcb_pkg::spcb_seq_t rx_st_ff;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire wr_fmt_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_FORMAT);
  wire wr_ctl_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_CONTROL);
  wire wr_sts_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_STATUS);
  wire rd_sts_w = reg_rd_i && (reg_addr_i == `SPCB_ADDR_STATUS);
  wire wr_txb_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_TXBUF);
  wire wr_brr_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_BITRATE);
  wire wr_crd_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_CARD);
  wire wr_ist_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_IRQST);
  wire wr_msk_w = reg_wr_i && (reg_addr_i == `SPCB_ADDR_IRQMSK);

  wire tx_empty_irq_en_w  = serial_control_ff[`SPCB_CTL_TIE];
  wire rx_irq_en_w        = serial_control_ff[`SPCB_CTL_RIE];
  wire tx_on_w            = serial_control_ff[`SPCB_CTL_TXON];
  wire rx_on_w            = serial_control_ff[`SPCB_CTL_RXON];
  wire addr_wake_filter_w = serial_control_ff[`SPCB_CTL_AWF];
  wire card_mode_sel_w    = card_mode_reg_ff[`SPCB_CARD_SEL];
  wire sync_mode_w        = serial_format_ff[`SPCB_FMT_SYNC];
  wire par_on_w           = serial_format_ff[`SPCB_FMT_PAR_ON] && !sync_mode_w;
  wire odd_w              = serial_format_ff[`SPCB_FMT_ODD];
  // Multiprocessor framing only in normal async operation
  wire multiproc_format_w = serial_format_ff[`SPCB_FMT_MP] && !sync_mode_w
                            && !card_mode_sel_w;
  wire filter_on_w        = addr_wake_filter_w && multiproc_format_w;

  wire [3:0] frame_len_w = sync_mode_w ? 4'h8 :
                           4'h9 + {3'h0, par_on_w} + {3'h0, multiproc_format_w};

  // --------------------------------------------------------------------
  // Bit timing
  // --------------------------------------------------------------------
  wire tick_w;
  wire bit_en_w = tick_w && (brr_cnt_ff == bit_rate_reg_ff);

  spcb_prescaler u_prescaler (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .sel_i      (serial_format_ff[1:0]),
    .tick_o     (tick_w)
  );

  // --------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------
  wire               sclk_rise_w = sclk_i && !sclk_q_ff;
  wire               rx_busy_w   = rx_st_ff == spcb_pkg::SPCB_BUSY;
  wire               rx_last_w;
  wire               rx_done_w;
  wire [FRAME_W-1:0] rx_frame_w;
  // Clocked mode has no start bit: the first serial clock edge is data
  wire rx_begin_w  = rx_on_w && !rx_busy_w &&
                     (sync_mode_w ? sclk_rise_w : (bit_en_w && !rxd_i));
  wire rx_sample_w = rx_on_w && (sync_mode_w ? sclk_rise_w : (bit_en_w && rx_busy_w));

  spcb_rx_shift #(.FRAME_W(FRAME_W)) u_rx_shift (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clr_i      (rx_begin_w),
    .sample_i   (rx_sample_w),
    .bit_i      (rxd_i),
    // Async frames store data, parity, address bit and stop; the start is not stored
    .len_i      (sync_mode_w ? 4'h8 : frame_len_w),
    .frame_o    (rx_frame_w),
    .last_o     (rx_last_w),
    .done_o     (rx_done_w)
  );

  wire [7:0] rx_data_w = rx_frame_w[7:0];
  wire       rx_mpb_w  = multiproc_format_w && rx_frame_w[{3'h0, par_on_w} + 4'h8];
  wire       rx_stop_w = rx_frame_w[frame_len_w - 4'h1];
  wire       rx_par_bad_w = par_on_w && ((^rx_data_w) ^ rx_frame_w[8] ^ odd_w);
  // Frames finishing while reception is off are thrown away
  wire       rx_end_w     = rx_done_w && rx_on_w;
  wire       rx_discard_w = rx_end_w && filter_on_w && !rx_mpb_w;
  wire       rx_accept_w  = rx_end_w && !rx_discard_w;
  wire       rx_load_w    = rx_accept_w && !rx_buf_full_flag_ff;
  wire       rx_wake_w    = rx_accept_w && rx_mpb_w;

  // --------------------------------------------------------------------
  // Status flag clearing: a zero write only clears a flag read as one
  // --------------------------------------------------------------------
  wire [4:0] flags_w = {tx_buf_empty_flag_ff, rx_buf_full_flag_ff, overrun_err_flag_ff,
                        framing_err_flag_ff, parity_err_flag_ff};
  wire [4:0] sw_clr_w = {5{wr_sts_w}} & ~reg_wdata_i[7:3] & armed_ff;

  // --------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------
  wire       tx_idle_w = tx_st_ff == spcb_pkg::SPCB_IDLE;
  wire       tx_load_w = tx_on_w && !tx_buf_empty_flag_ff && tx_idle_w;
  wire       tx_par_w  = (^tx_buf_reg_ff) ^ odd_w;
  wire       tx_mpb_w  = multiproc_format_w ? tx_addr_bit_ff : 1'b1;
  wire [2:0] tx_tail_w = par_on_w ? {1'b1, tx_mpb_w, tx_par_w} : {2'b11, tx_mpb_w};
  wire [FRAME_W-1:0] tx_image_w = sync_mode_w ? {{(FRAME_W-8){1'b1}}, tx_buf_reg_ff} :
                                  {tx_tail_w, tx_buf_reg_ff, 1'b0};

  // --------------------------------------------------------------------
  // Next values of control and flags
  // --------------------------------------------------------------------
  logic [7:0] nxt_serial_control;
  logic       nxt_tx_buf_empty_flag;
  logic       nxt_rx_buf_full_flag;
  logic       nxt_overrun_err_flag;
  logic       nxt_framing_err_flag;
  logic       nxt_parity_err_flag;

  always_comb begin
    nxt_serial_control = wr_ctl_w ? (reg_wdata_i & `SPCB_CTL_MASK) : serial_control_ff;
    if (rx_wake_w) begin
      nxt_serial_control[`SPCB_CTL_AWF] = 1'b0;
    end
    nxt_tx_buf_empty_flag = (tx_buf_empty_flag_ff && !sw_clr_w[4]) || tx_load_w
                            || !tx_on_w;
    // Events win over a clear in the same cycle
    nxt_rx_buf_full_flag = (rx_buf_full_flag_ff && !sw_clr_w[3]) || rx_load_w;
    nxt_overrun_err_flag = (overrun_err_flag_ff && !sw_clr_w[2])
                           || (rx_accept_w && rx_buf_full_flag_ff);
    nxt_framing_err_flag = (framing_err_flag_ff && !sw_clr_w[1])
                           || (rx_accept_w && !sync_mode_w && !rx_stop_w);
    nxt_parity_err_flag  = (parity_err_flag_ff && !sw_clr_w[0])
                           || (rx_accept_w && rx_par_bad_w);
  end

  // --------------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------------
  assign tx_empty_irq_o = tx_empty_irq_en_w && tx_buf_empty_flag_ff;
  assign rx_full_irq_o  = rx_irq_en_w && rx_buf_full_flag_ff;
  assign rx_error_irq_o = rx_irq_en_w && (overrun_err_flag_ff || framing_err_flag_ff
                                          || parity_err_flag_ff);
  wire [2:0] req_w   = {rx_error_irq_o, rx_full_irq_o, tx_empty_irq_o};
  wire [2:0] irq_ev_w = req_w & ~req_q_ff;
  wire [2:0] ist_clr_w = wr_ist_w ? reg_wdata_i[2:0] : 3'h0;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  wire [7:0] status_w = {flags_w, 1'b0, addr_flag_bit_ff, tx_addr_bit_ff};
  wire [7:0] rd_val_w =
    (reg_addr_i == `SPCB_ADDR_FORMAT)  ? serial_format_ff :
    (reg_addr_i == `SPCB_ADDR_CONTROL) ? serial_control_ff :
    (reg_addr_i == `SPCB_ADDR_STATUS)  ? status_w :
    (reg_addr_i == `SPCB_ADDR_TXBUF)   ? tx_buf_reg_ff :
    (reg_addr_i == `SPCB_ADDR_RXBUF)   ? rx_buf_reg_ff :
    (reg_addr_i == `SPCB_ADDR_BITRATE) ? bit_rate_reg_ff :
    (reg_addr_i == `SPCB_ADDR_CARD)    ? card_mode_reg_ff :
    (reg_addr_i == `SPCB_ADDR_IRQST)   ? {5'h00, irq_stat_ff} :
    (reg_addr_i == `SPCB_ADDR_IRQMSK)  ? {5'h00, irq_mask_ff} : 8'h00;

  // --------------------------------------------------------------------
  // Register and flag storage
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_format_ff  <= `SPCB_RST_REG;
      serial_control_ff <= `SPCB_RST_REG;
      tx_buf_reg_ff     <= `SPCB_RST_REG;
      bit_rate_reg_ff   <= `SPCB_RST_REG;
      card_mode_reg_ff  <= `SPCB_RST_REG;
      irq_mask_ff       <= 3'h0;
      reg_rdata_o       <= 8'h00;
    end else begin
      serial_control_ff <= nxt_serial_control;
      reg_rdata_o       <= reg_rd_i ? rd_val_w : 8'h00;
      if (wr_fmt_w) serial_format_ff <= reg_wdata_i;
      if (wr_txb_w) tx_buf_reg_ff <= reg_wdata_i;
      if (wr_brr_w) bit_rate_reg_ff <= reg_wdata_i;
      if (wr_crd_w) card_mode_reg_ff <= reg_wdata_i;
      if (wr_msk_w) irq_mask_ff <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_buf_empty_flag_ff <= 1'b1;
      rx_buf_full_flag_ff  <= 1'b0;
      overrun_err_flag_ff  <= 1'b0;
      framing_err_flag_ff  <= 1'b0;
      parity_err_flag_ff   <= 1'b0;
      addr_flag_bit_ff     <= 1'b0;
      tx_addr_bit_ff       <= 1'b0;
      armed_ff             <= 5'h00;
      rx_buf_reg_ff        <= 8'h00;
    end else begin
      tx_buf_empty_flag_ff <= nxt_tx_buf_empty_flag;
      rx_buf_full_flag_ff  <= nxt_rx_buf_full_flag;
      overrun_err_flag_ff  <= nxt_overrun_err_flag;
      framing_err_flag_ff  <= nxt_framing_err_flag;
      parity_err_flag_ff   <= nxt_parity_err_flag;
      armed_ff <= rd_sts_w ? flags_w : (wr_sts_w ? 5'h00 : armed_ff);
      if (wr_sts_w) tx_addr_bit_ff <= reg_wdata_i[`SPCB_STS_MPBT];
      if (rx_accept_w) addr_flag_bit_ff <= rx_mpb_w;
      if (rx_load_w) rx_buf_reg_ff <= rx_data_w;
    end
  end

  // --------------------------------------------------------------------
  // Sequencers and timing
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brr_cnt_ff  <= 8'h00;
      sclk_q_ff   <= 1'b0;
      irq_stat_ff <= 3'h0;
      req_q_ff    <= 3'h0;
      rx_st_ff    <= spcb_pkg::SPCB_IDLE;
    end else begin
      sclk_q_ff   <= sclk_i;
      req_q_ff    <= req_w;
      irq_stat_ff <= (irq_stat_ff & ~ist_clr_w) | irq_ev_w;
      if (tick_w) brr_cnt_ff <= bit_en_w ? 8'h00 : brr_cnt_ff + 8'h01;
      if (!rx_on_w || rx_last_w) begin
        rx_st_ff <= spcb_pkg::SPCB_IDLE;
      end else if (rx_begin_w) begin
        rx_st_ff <= spcb_pkg::SPCB_BUSY;
      end
    end
  end

  // Dropping transmit on aborts a frame and idles the line high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_ff    <= spcb_pkg::SPCB_IDLE;
      tx_frame_ff <= '1;
      tx_cnt_ff   <= 4'h0;
      txd_o       <= 1'b1;
    end else if (!tx_on_w) begin
      tx_st_ff <= spcb_pkg::SPCB_IDLE;
      txd_o    <= 1'b1;
    end else if (tx_load_w) begin
      tx_st_ff    <= spcb_pkg::SPCB_BUSY;
      tx_frame_ff <= tx_image_w;
      tx_cnt_ff   <= 4'h0;
    end else if (!tx_idle_w && bit_en_w) begin
      if (tx_cnt_ff == frame_len_w) begin
        tx_st_ff <= spcb_pkg::SPCB_IDLE;
        txd_o    <= 1'b1;
      end else begin
        txd_o       <= tx_frame_ff[0];
        tx_frame_ff <= {1'b1, tx_frame_ff[FRAME_W-1:1]};
        tx_cnt_ff   <= tx_cnt_ff + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  wire [3:0] rx_flags_w = {rx_buf_full_flag_ff, overrun_err_flag_ff,
                           framing_err_flag_ff, parity_err_flag_ff};

  sequence s_clear_tx_buf_empty_flag;
    wr_sts_w && armed_ff[4] && !reg_wdata_i[`SPCB_STS_TX_BUF_EMPTY_FLAG];
  endsequence

  sequence s_filtered_end;
    rx_end_w && filter_on_w && !rx_mpb_w;
  endsequence

  a_tx_irq_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !tx_empty_irq_en_w |-> !tx_empty_irq_o)
    else $error("transmit-empty request while disabled");

  a_tx_irq_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (tx_empty_irq_o && tx_on_w && !wr_ctl_w) ##0 s_clear_tx_buf_empty_flag |=> !tx_empty_irq_o)
    else $error("transmit-empty request not withdrawn");

  a_rx_irq_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !rx_irq_en_w |-> !(rx_full_irq_o || rx_error_irq_o))
    else $error("receive request while disabled");

  a_rx_irq_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_ctl_w && !reg_wdata_i[`SPCB_CTL_RIE]) |=> !(rx_full_irq_o || rx_error_irq_o))
    else $error("receive request not withdrawn");

  a_tx_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tx_load_w |=> (tx_st_ff == spcb_pkg::SPCB_BUSY) && tx_buf_empty_flag_ff
                  ##1 (txd_o == 1'b1 || tx_st_ff == spcb_pkg::SPCB_BUSY))
    else $error("frame did not start after load");

  a_tx_off_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !tx_on_w |=> tx_buf_empty_flag_ff && txd_o)
    else $error("empty flag not held while transmit off");

  a_rx_off_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!rx_on_w && !wr_sts_w) |=> $stable(rx_flags_w))
    else $error("receive flags moved while receive off");

  a_filter_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (s_filtered_end and !wr_sts_w) |=> $stable(rx_flags_w) && $stable(rx_buf_reg_ff))
    else $error("filtered frame changed receive state");

  a_wake_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rx_end_w && filter_on_w && rx_mpb_w) |=> addr_flag_bit_ff && !addr_wake_filter_w)
    else $error("address frame did not wake receiver");

  a_filter_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sync_mode_w || card_mode_sel_w) |-> !filter_on_w)
    else $error("filter active outside normal async mode");

  a_rx_begin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rx_begin_w && !rx_last_w && !wr_ctl_w) |=> rx_st_ff == spcb_pkg::SPCB_BUSY)
    else $error("reception did not start");

endmodule

// ==== verif/spcb_peer.sv ====
// ----------------------------------------
// Remote transmitter on the line, async or clocked
// ----------------------------------------
module spcb_peer (
  // Clock
  input  wire logic core_clk_i,
  // Line toward the device
  output logic      rxd_o,
  output logic      sclk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_o = 1'b1;
  initial sclk_o = 1'b0;
  // Clocked mode: data set while the clock is low, taken on its rising edge
  task automatic send_sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_i);
      rxd_o  <= d[i];
      sclk_o <= 1'b0;
      @(posedge core_clk_i);
      sclk_o <= 1'b1;
    end
    @(posedge core_clk_i);
    rxd_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
  endtask
  // One clock per bit; the line rests high after the stop bit
  task automatic send(input logic [7:0] d, input logic mp_on, input logic mp);
    logic [10:0] f;
    int          n;
    f = mp_on ? {1'b1, mp, d, 1'b0} : {2'b11, d, 1'b0};
    n = mp_on ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      rxd_o <= f[i];
    end
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule

// ==== verif/testbench.sv ====
// ----------------------------------------
// Register-level tests
// ----------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i  = 1'b0;
  logic       rst_i       = 1'b1;
  logic [3:0] reg_addr_i  = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       rxd_i;
  logic       sclk_i;
  logic       txd_o;
  logic       tx_empty_irq_o;
  logic       rx_full_irq_o;
  logic       rx_error_irq_o;
  logic       irq_o;
  int         fails       = 0;
  int         checks_done = 0;
  always #25 core_clk_i = ~core_clk_i;
  spcb_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_i), .sclk_i(sclk_i), .txd_o(txd_o),
    .tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
    .rx_error_irq_o(rx_error_irq_o), .irq_o(irq_o));
  spcb_peer peer (.core_clk_i(core_clk_i), .rxd_o(rxd_i), .sclk_o(sclk_i));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk("reg", e, reg_rdata_o);
  endtask
  // Bits sampled at the last clock of each bit so a wrong divide shifts the pattern
  task automatic txf(input logic [1:0] s, input logic [7:0] d);
    logic [9:0] f;
    int         dv;
    int         k;
    f  = {1'b1, d, 1'b0};
    dv = (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 16 : 64;
    k  = 0;
    wr(4'h1, 8'h00);
    wr(4'h0, {6'h00, s});
    wr(4'h1, 8'ha0);
    wr(4'h3, d);
    rc(4'h2, 8'h80);
    wr(4'h2, 8'h00);
    chk("tx_irq", 8'h00, {7'h00, tx_empty_irq_o});
    while (txd_o !== 1'b0 && k < 200) begin
      @(negedge core_clk_i);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      repeat ((i == 0) ? dv - 1 : dv) @(negedge core_clk_i);
      chk("txd", {7'h00, f[i]}, {7'h00, txd_o});
    end
    repeat (2 * dv) @(posedge core_clk_i);
  endtask
  task automatic finish_test;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rc(4'h0, 8'h00);
    rc(4'h1, 8'h00);
    rc(4'h2, 8'h80);
    rc(4'h9, 8'h00);
    chk("irq", 8'h00, {5'h00, tx_empty_irq_o, rx_full_irq_o, irq_o});
    $display("test reset done");
    wr(4'h1, 8'h80);
    chk("tx_irq", 8'h01, {7'h00, tx_empty_irq_o});
    wr(4'h8, 8'h01);
    chk("irq_o", 8'h01, {7'h00, irq_o});
    wr(4'h8, 8'h00);
    chk("irq_o", 8'h00, {7'h00, irq_o});
    wr(4'h7, 8'h01);
    rc(4'h7, 8'h00);
    wr(4'h1, 8'h00);
    chk("tx_irq", 8'h00, {7'h00, tx_empty_irq_o});
    $display("test irq done");
    for (int s = 0; s < 4; s++) txf(s[1:0], 8'h35 ^ s[7:0]);
    $display("test tx done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h50);
    peer.send(8'h3c, 1'b0, 1'b0);
    chk("rx_irq", 8'h01, {7'h00, rx_full_irq_o});
    rc(4'h4, 8'h3c);
    rc(4'h2, 8'hc0);
    wr(4'h2, 8'h00);
    chk("rx_irq", 8'h00, {7'h00, rx_full_irq_o});
    peer.send(8'ha5, 1'b0, 1'b0);
    peer.send(8'h5a, 1'b0, 1'b0);
    chk("rx_err", 8'h01, {7'h00, rx_error_irq_o});
    wr(4'h1, 8'h40);
    rc(4'h2, 8'he0);
    rc(4'h4, 8'ha5);
    wr(4'h2, 8'h00);
    chk("rx_err", 8'h00, {7'h00, rx_error_irq_o});
    $display("test rx done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h58);
    peer.send(8'h11, 1'b1, 1'b0);
    rc(4'h2, 8'h80);
    peer.send(8'h22, 1'b1, 1'b1);
    rc(4'h2, 8'hc2);
    rc(4'h1, 8'h50);
    rc(4'h4, 8'h22);
    $display("test addr wake done");
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h50);
    peer.send_sync(8'h96);
    rc(4'h4, 8'h96);
    rc(4'h2, 8'hc0);
    $display("test clocked rx done");
    finish_test;
  end
endmodule
